// [misc_config_pkg.sv]
// constants for the miscellaneous pci configuration register of the ohci function
// assumes a 256-byte configuration space with byte addresses and dword accesses
package misc_config_pkg;
    // placement in configuration space
    localparam logic [7:0] MISC_CFG_OFFSET = 8'hf0;
    // field positions
    localparam int PME_DEEP_OFF_BIT = 15;
    localparam int PCI23_BIT = 11;
    localparam int PME_SKIP_BIT = 10;
    localparam int LRCS_LO_BIT = 8;
    localparam int VENDOR_ID_FLAG_BIT = 26;
    // value after reset
    localparam logic [31:0] MISC_CFG_RESET = 32'h00000a90;
    // bits of the low byte that hold storage; bits 6 and 5 read as zero
    localparam logic [7:0] LOW_BYTE_RW_MASK = 8'h9f;
    // read command select codes
    localparam logic [1:0] LRCS_LINE = 2'h0;
    localparam logic [1:0] LRCS_PLAIN = 2'h1;
    localparam logic [1:0] LRCS_MULTIPLE = 2'h2;
    // pci bus command codes
    localparam logic [3:0] CMD_MEM_READ = 4'h6;
    localparam logic [3:0] CMD_MEM_READ_MULTIPLE = 4'hc;
    localparam logic [3:0] CMD_MEM_READ_LINE = 4'he;
    // longest read that always uses a plain memory read
    localparam int SHORT_READ_PHASES = 2;
endpackage

// [read_cmd_if.sv]
// carrier between the register bank and the read command picker
// assumes both ends run on the same configuration clock
`timescale 1ns/10ps
interface read_cmd_if #(
    parameter int PHASE_W = 8
);
    logic [1:0] selectField;
    logic [PHASE_W-1:0] phaseCount;
    logic [3:0] command;

    modport picker (
        input selectField,
        input phaseCount,
        output command
    );
    modport owner (
        output selectField,
        output phaseCount,
        input command
    );
endinterface

// [read_cmd_picker.sv]
// picks the pci read command for a master read of a given length
// assumes the owner registers the result
`timescale 1ns/10ps
module read_cmd_picker #(
    parameter int PHASE_W = 8
) (
    read_cmd_if.picker rc
);
    localparam logic [PHASE_W-1:0] SHORT_LIMIT = PHASE_W'(misc_config_pkg::SHORT_READ_PHASES);

    wire isShort = (rc.phaseCount <= SHORT_LIMIT);
    wire [3:0] longCommand;

    // the reserved code falls back to the reset code, read multiple
    assign longCommand = (rc.selectField == misc_config_pkg::LRCS_LINE) ?
                         misc_config_pkg::CMD_MEM_READ_LINE :
                         (rc.selectField == misc_config_pkg::LRCS_PLAIN) ?
                         misc_config_pkg::CMD_MEM_READ :
                         misc_config_pkg::CMD_MEM_READ_MULTIPLE;
    assign rc.command = isShort ? misc_config_pkg::CMD_MEM_READ : longCommand;
endmodule

// [ohci_misc_config.sv]
// miscellaneous pci configuration register of the ohci function, with the
// pme gating and the read command choice that it steers
// assumes one-cycle access strobes from the configuration decoder, all
// inputs synchronous to clock
//
// Functional notes
// - bits 31 to 16 read zero, writes to them are dropped.
// - pme-from-deep-off flag bit 15 is tied to zero.
// - bits 14 to 12 read zero.
// - pci 2.3 conformance flag bit 11 is tied to one, writes ignored.
// - read-write bit 10 is mirrored to vendor id bit 26.
// - bit 10 clear: pme needs master irq enable; set: enable ignored.
// - reads of one or two data phases always use plain memory read.
// - longer reads use select field: 00 line, 01 plain, 10 multiple.
// - reserved select code 11 behaves as read multiple.
// - register sits at configuration offset f0h of the ohci function.
`timescale 1ns/10ps
module ohci_misc_config #(
    parameter int PHASE_W = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // configuration access port
    input wire logic cfgWrite,
    input wire logic cfgRead,
    input wire logic [7:0] cfgAddr,
    input wire logic [3:0] cfgByteEn,
    input wire logic [31:0] cfgWriteData,
    output logic [31:0] cfgReadData,
    output logic cfgReadValid,
    output logic cfgReadHit,
    // pme generation
    input wire logic unmaskedIrqPending,
    input wire logic master_interrupt_enable,
    output logic pmeRequest,
    // vendor identification mirror
    output logic vendorIdFlag,
    // pci master read command
    input wire logic readRequest,
    input wire logic [PHASE_W-1:0] readPhases,
    output logic [3:0] readCommand,
    output logic readCommandValid,
    // low byte controls used elsewhere in the function
    output logic pmVersionCtrl,
    output logic noTargetAbort,
    output logic serialBusEnable,
    output logic keepPhyClock,
    output logic keepPciClock,
    output logic keepPclkRunning
);
    // stored state
    logic pme_skip_master_irq_gate_reg;
    logic pme_skip_master_irq_gate_next;
    logic [1:0] long_read_command_select_reg;
    logic [1:0] long_read_command_select_next;
    logic [7:0] lowByte_reg;
    logic [7:0] lowByte_next;
    // answers
    logic [31:0] cfgReadData_reg;
    logic cfgReadValid_reg;
    logic cfgReadHit_reg;
    logic pmeRequest_reg;
    logic vendorIdFlag_reg;
    logic [3:0] readCommand_reg;
    logic readCommandValid_reg;

    read_cmd_if #(.PHASE_W(PHASE_W)) rcBus ();

    read_cmd_picker #(.PHASE_W(PHASE_W)) picker (
        .rc(rcBus)
    );

    // address decode: only the dword at the misc offset belongs here
    wire addrHit = (cfgAddr[7:2] == misc_config_pkg::MISC_CFG_OFFSET[7:2]);
    wire writeHit = cfgWrite && addrHit;
    wire writeByte1 = writeHit && cfgByteEn[1];
    wire writeByte0 = writeHit && cfgByteEn[0];

    // byte lanes 2 and 3 have no storage, so their writes vanish
    assign pme_skip_master_irq_gate_next = writeByte1 ?
                                           cfgWriteData[misc_config_pkg::PME_SKIP_BIT] :
                                           pme_skip_master_irq_gate_reg;
    assign long_read_command_select_next = writeByte1 ?
                                           cfgWriteData[misc_config_pkg::LRCS_LO_BIT +: 2] :
                                           long_read_command_select_reg;
    assign lowByte_next = writeByte0 ?
                          (cfgWriteData[7:0] & misc_config_pkg::LOW_BYTE_RW_MASK) :
                          lowByte_reg;

    // read image of the whole register
    wire [31:0] regImage;
    assign regImage[31:16] = 16'h0000;
    assign regImage[15] = 1'b0;
    assign regImage[14:12] = 3'h0;
    assign regImage[11] = 1'b1;
    assign regImage[10] = pme_skip_master_irq_gate_reg;
    assign regImage[9:8] = long_read_command_select_reg;
    assign regImage[7:0] = lowByte_reg;

    // unmapped addresses read zero with the hit flag low
    wire [31:0] readData = addrHit ? regImage : 32'h00000000;

    // pme path: the gate is bypassed while the skip bit is set
    wire pmeNext = unmaskedIrqPending &&
                   (master_interrupt_enable || pme_skip_master_irq_gate_reg);

    assign rcBus.selectField = long_read_command_select_reg;
    assign rcBus.phaseCount = readPhases;

    // reset of the register fields
    localparam logic PME_SKIP_RESET = misc_config_pkg::MISC_CFG_RESET[10];
    localparam logic [1:0] LRCS_RESET = misc_config_pkg::MISC_CFG_RESET[9:8];
    localparam logic [7:0] LOW_RESET = misc_config_pkg::MISC_CFG_RESET[7:0];

    always_ff @(posedge clock) begin
        if (!nrst) begin
            pme_skip_master_irq_gate_reg <= PME_SKIP_RESET;
            long_read_command_select_reg <= LRCS_RESET;
            lowByte_reg <= LOW_RESET;
        end else begin
            pme_skip_master_irq_gate_reg <= pme_skip_master_irq_gate_next;
            long_read_command_select_reg <= long_read_command_select_next;
            lowByte_reg <= lowByte_next;
        end
    end

    // read answers one cycle after the strobe
    always_ff @(posedge clock) begin
        if (!nrst) begin
            cfgReadData_reg <= 32'h00000000;
            cfgReadValid_reg <= 1'b0;
            cfgReadHit_reg <= 1'b0;
        end else begin
            cfgReadData_reg <= cfgRead ? readData : 32'h00000000;
            cfgReadValid_reg <= cfgRead;
            cfgReadHit_reg <= cfgRead && addrHit;
        end
    end

    // pme request and the mirrored vendor flag are registered; the vendor flag follows stored bit 10 one cycle late
    always_ff @(posedge clock) begin
        if (!nrst) begin
            pmeRequest_reg <= 1'b0;
            vendorIdFlag_reg <= 1'b0;
        end else begin
            pmeRequest_reg <= pmeNext;
            vendorIdFlag_reg <= pme_skip_master_irq_gate_reg;
        end
    end

    // command is held until the next request so the master can sample late
    always_ff @(posedge clock) begin
        if (!nrst) begin
            readCommand_reg <= misc_config_pkg::CMD_MEM_READ;
            readCommandValid_reg <= 1'b0;
        end else begin
            readCommandValid_reg <= readRequest;
            if (readRequest) begin
                readCommand_reg <= rcBus.command;
            end
        end
    end

    assign cfgReadData = cfgReadData_reg;
    assign cfgReadValid = cfgReadValid_reg;
    assign cfgReadHit = cfgReadHit_reg;
    assign pmeRequest = pmeRequest_reg;
    assign vendorIdFlag = vendorIdFlag_reg;
    assign readCommand = readCommand_reg;
    assign readCommandValid = readCommandValid_reg;
    assign pmVersionCtrl = lowByte_reg[7];
    assign noTargetAbort = lowByte_reg[4];
    assign serialBusEnable = lowByte_reg[3];
    assign keepPhyClock = lowByte_reg[2];
    assign keepPciClock = lowByte_reg[1];
    assign keepPclkRunning = lowByte_reg[0];
endmodule

// [misc_cfg_checker.sv]
// port checker for the misc configuration register bank
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/10ps
module misc_cfg_checker #(parameter int PHASE_W = 8) (
    // clock, reset, configuration port
    input wire logic clock,
    input wire logic nrst,
    input wire logic cfgRead,
    input wire logic [7:0] cfgAddr,
    input wire logic [31:0] cfgReadData,
    input wire logic cfgReadHit,
    input wire logic cfgReadValid,
    // pme, mirror, read command
    input wire logic unmaskedIrqPending,
    input wire logic master_interrupt_enable,
    input wire logic pmeRequest,
    input wire logic vendorIdFlag,
    input wire logic readRequest,
    input wire logic [PHASE_W-1:0] readPhases,
    input wire logic [3:0] readCommand,
    input wire logic readCommandValid
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    upper_half_zero_a: assert property (cfgReadHit |-> cfgReadData[31:16] == 16'h0000)
        else $error("upper half not zero");
    deep_off_zero_a: assert property (cfgReadHit |-> !cfgReadData[15])
        else $error("deep-off flag set");
    reserved_zero_a: assert property (cfgReadHit |-> cfgReadData[14:12] == 3'h0)
        else $error("reserved bits set");
    conformance_set_a: assert property (cfgReadHit |-> cfgReadData[11])
        else $error("conformance flag clear");
    vendor_mirror_a: assert property (cfgReadHit |-> cfgReadData[10] == vendorIdFlag)
        else $error("vendor flag differs");
    // vendorIdFlag already lags bit 10 by one cycle, matching the pme delay
    pme_gate_a: assert property (nrst |=> pmeRequest == ($past(unmaskedIrqPending)
        & ($past(master_interrupt_enable) | vendorIdFlag))) else $error("pme wrong");
    short_read_a: assert property (readRequest && readPhases <= 2
        |=> readCommandValid && readCommand == 4'h6) else $error("short read cmd");
    long_read_a: assert property (readRequest && readPhases > 2
        |=> readCommandValid && readCommand inside {4'h6, 4'hc, 4'he})
        else $error("long read cmd");
    offset_hit_a: assert property (cfgRead
        |=> cfgReadHit == ($past(cfgAddr[7:2]) == 6'h3c)) else $error("hit mismatch");
    read_valid_a: assert property (nrst |=> cfgReadValid == $past(cfgRead))
        else $error("read valid wrong");
    miss_data_zero_a: assert property (cfgReadValid && !cfgReadHit |-> cfgReadData == 32'h0)
        else $error("miss data not zero");
endmodule

bind ohci_misc_config misc_cfg_checker #(.PHASE_W(PHASE_W)) u_chk (.clock(clock),
    .nrst(nrst), .cfgRead(cfgRead), .cfgAddr(cfgAddr), .cfgReadData(cfgReadData),
    .cfgReadHit(cfgReadHit), .cfgReadValid(cfgReadValid),
    .unmaskedIrqPending(unmaskedIrqPending),
    .master_interrupt_enable(master_interrupt_enable), .pmeRequest(pmeRequest),
    .vendorIdFlag(vendorIdFlag), .readRequest(readRequest), .readPhases(readPhases),
    .readCommand(readCommand), .readCommandValid(readCommandValid));

// [cfg_host_model.sv]
// host model issuing configuration reads and writes
// assumes the bench calls its tasks from a single process
`timescale 1ns/10ps
module cfg_host_model (
    // clock
    input wire logic clock,
    // configuration port
    output logic cfgWrite = 1'b0,
    output logic cfgRead = 1'b0,
    output logic [7:0] cfgAddr = 8'h00,
    output logic [3:0] cfgByteEn = 4'h0,
    output logic [31:0] cfgWriteData = 32'h0,
    input wire logic [31:0] cfgReadData,
    input wire logic cfgReadHit
);
    // released address and write data lines show inverted values so stale data cannot pass; byte enables keep their value
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge clock);
        cfgWrite <= 1'b1;
        cfgAddr <= a;
        cfgByteEn <= be;
        cfgWriteData <= d;
        @(posedge clock);
        cfgWrite <= 1'b0;
        cfgAddr <= ~a;
        cfgWriteData <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic h);
        @(posedge clock);
        cfgRead <= 1'b1;
        cfgAddr <= a;
        @(posedge clock);
        cfgRead <= 1'b0;
        cfgAddr <= ~a;
        @(negedge clock);
        d = cfgReadData;
        h = cfgReadHit;
    endtask
endmodule

// [test_ohci_misc_config.sv]
// self-checking bench for the misc configuration register bank
// assumes the host model drives the configuration port
`timescale 1ns/10ps
module test_ohci_misc_config;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic cfgWrite, cfgRead, cfgReadValid, cfgReadHit, hit;
    logic [7:0] cfgAddr;
    logic [3:0] cfgByteEn, readCommand;
    logic [31:0] cfgWriteData, cfgReadData, rdata;
    logic unmaskedIrqPending = 1'b0;
    logic master_interrupt_enable = 1'b0;
    logic readRequest = 1'b0;
    logic [7:0] readPhases = 8'h00;
    logic pmeRequest, vendorIdFlag, readCommandValid;
    // low byte controls: version, no-abort, serial bus, phy, pci, pclk
    wire [5:0] lowCtl;
    int n_mismatch = 0;
    int checks_done = 0;
    // select, phases, expected command
    logic [13:0] rows [8] = '{14'h0016, 14'h0026, 14'h003e, 14'h1036, 14'h203c,
        14'h303c, 14'h3006, 14'h0ffe};
    always #10 clock = ~clock;
    ohci_misc_config #(.PHASE_W(8)) u_dut (.clock(clock), .nrst(nrst),
        .cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn),
        .cfgWriteData(cfgWriteData), .cfgReadData(cfgReadData), .cfgReadValid(cfgReadValid),
        .cfgReadHit(cfgReadHit), .unmaskedIrqPending(unmaskedIrqPending),
        .master_interrupt_enable(master_interrupt_enable), .pmeRequest(pmeRequest),
        .vendorIdFlag(vendorIdFlag), .readRequest(readRequest), .readPhases(readPhases),
        .readCommand(readCommand), .readCommandValid(readCommandValid),
        .pmVersionCtrl(lowCtl[5]), .noTargetAbort(lowCtl[4]), .serialBusEnable(lowCtl[3]),
        .keepPhyClock(lowCtl[2]), .keepPciClock(lowCtl[1]), .keepPclkRunning(lowCtl[0]));
    cfg_host_model u_host (.clock(clock), .cfgWrite(cfgWrite), .cfgRead(cfgRead),
        .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWriteData(cfgWriteData),
        .cfgReadData(cfgReadData), .cfgReadHit(cfgReadHit));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic ask(input logic [7:0] p);
        @(posedge clock);
        readRequest <= 1'b1;
        readPhases <= p;
        @(posedge clock);
        readRequest <= 1'b0;
        readPhases <= ~p;
        @(negedge clock);
    endtask
    task automatic pme_is(input logic e);
        repeat (2) @(negedge clock);
        check({31'h0, pmeRequest}, {31'h0, e});
    endtask
    initial begin
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        u_host.rd(8'hf0, rdata, hit);
        check(rdata, 32'h00000a90);
        check({26'h0, lowCtl}, 32'h00000030);
        u_host.wr(8'hf0, 4'hf, 32'hffffffff);
        u_host.rd(8'hf0, rdata, hit);
        check(rdata, 32'h00000f9f);
        check({31'h0, vendorIdFlag}, 32'h1);
        u_host.rd(8'hf4, rdata, hit);
        check(rdata | {31'h0, hit}, 32'h0);
        for (int i = 0; i < 8; i++) begin
            u_host.wr(8'hf0, 4'h2, {22'h0, rows[i][13:12], 8'h00});
            ask(rows[i][11:4]);
            check({28'h0, readCommand}, {28'h0, rows[i][3:0]});
        end
        @(posedge clock);
        unmaskedIrqPending <= 1'b1;
        pme_is(1'b0);
        u_host.wr(8'hf0, 4'h2, 32'h00000400);
        pme_is(1'b1);
        u_host.wr(8'hf0, 4'h2, 32'h00000000);
        master_interrupt_enable <= 1'b1;
        pme_is(1'b1);
        // second reset in mid-run must restore the default word
        u_host.wr(8'hf0, 4'h3, 32'h00000700);
        nrst <= 1'b0;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        u_host.rd(8'hf0, rdata, hit);
        check(rdata, 32'h00000a90);
        check({26'h0, lowCtl}, 32'h00000030);
        complete_run();
    end
endmodule
